// File: pkg/twcr_pkg.sv
// package: register map, field positions, reset values and timing counts
package twcr_pkg;
    // register offsets (byte-wide registers, index = offset)
    localparam logic [3:0] OFS_COMMON   = 4'h0;
    localparam logic [3:0] OFS_DUAL     = 4'h1;
    localparam logic [3:0] OFS_DEBUG    = 4'h2;
    localparam logic [3:0] OFS_MCTL1    = 4'h3;
    localparam logic [3:0] OFS_MCTL2    = 4'h4;
    localparam logic [3:0] OFS_MSTATE   = 4'h5;
    localparam logic [3:0] OFS_MRATE    = 4'h6;
    localparam logic [3:0] OFS_MADR     = 4'h7;
    localparam logic [3:0] OFS_MBYTE    = 4'h8;
    localparam logic [3:0] OFS_SCTL1    = 4'h9;
    localparam logic [3:0] OFS_SCTL2    = 4'ha;
    localparam logic [3:0] OFS_SSTATE   = 4'hb;
    localparam logic [3:0] OFS_SOWN     = 4'hc;
    localparam logic [3:0] OFS_SBYTE    = 4'hd;
    localparam logic [3:0] OFS_SMASK    = 4'he;
    localparam logic [3:0] OFS_IRQ_STAT = 4'hf; // sticky event status
    // mask register lives above the 4-bit space; 5-bit address bus
    localparam logic [4:0] OFS_IRQ_MASK = 5'h10;

    // writable bit masks, unimplemented bits read zero
    localparam logic [7:0] WMASK_COMMON = 8'h5e;
    localparam logic [7:0] WMASK_DUAL   = 8'h4f;
    localparam logic [7:0] WMASK_DEBUG  = 8'h01;
    localparam logic [7:0] WMASK_MCTL1  = 8'hdf;
    localparam logic [7:0] WMASK_MCTL2  = 8'h04; // ack_choice only stored
    localparam logic [7:0] WMASK_IRQ    = 8'h07;
    localparam logic [7:0] RESET_VAL    = 8'h00;

    // field positions
    localparam int SETUP_BIT  = 4;
    localparam int HOLD_LSB   = 2;
    localparam int FPLUS_BIT  = 1;
    localparam int DUAL_EN    = 0;
    localparam int RUN_BIT    = 0;
    localparam int READ_IRQ_ENABLE_BIT   = 7;
    localparam int WRITE_IRQ_ENABLE_BIT   = 6;
    localparam int QC_BIT     = 4;
    localparam int TMO_LSB    = 2;
    localparam int SMART_BIT  = 1;
    localparam int MEN_BIT    = 0;
    localparam int ACK_BIT    = 2;
    localparam int FLUSH_BIT  = 3;
    localparam int RDF_BIT    = 7;
    localparam int WRF_BIT    = 6;
    localparam int EV_RD      = 0;
    localparam int EV_WR      = 1;
    localparam int EV_TMO     = 2;

    // hold encodings
    localparam logic [1:0] HOLD_OFF   = 2'h0;
    localparam logic [1:0] HOLD_SHORT = 2'h1;
    localparam logic [1:0] HOLD_300   = 2'h2;
    localparam logic [1:0] HOLD_500   = 2'h3;
    localparam logic [1:0] CMD_STOP   = 2'h3;

    // timing
    localparam int CLK_NS       = 10;
    localparam int SETUP_SHORT  = 4;
    localparam int SETUP_LONG   = 8;
    localparam int TMO_50_US    = 50;
    localparam int TMO_100_US   = 100;
    localparam int TMO_200_US   = 200;
    localparam int TMO_50_CYC   = TMO_50_US * 1000 / CLK_NS;
    localparam int TMO_100_CYC  = TMO_100_US * 1000 / CLK_NS;
    localparam int TMO_200_CYC  = TMO_200_US * 1000 / CLK_NS;

    // effective per-section configuration
    typedef struct packed {
        logic [1:0] hold;
        logic       fast_plus;
        logic [3:0] setup_cyc;
    } twcr_cfg_s;

    typedef enum logic [2:0] {
        BS_UNKNOWN = 3'b001,
        BS_IDLE    = 3'b010,
        BS_BUSY    = 3'b100
    } twcr_bus_e;
endpackage

// File: hw/twcr_regs.sv
// two-wire unit configuration registers, master control and bus time-out
`timescale 1ns/100ps
// How it works
// - slave sda setup is 4 cycles when select bit 0, 8 when 1
// - hold selector 0 off, 1 short, 2 about 300 ns, 3 about 500 ns
// - common fast-plus picks 1 MHz for unit, or master only in dual mode
// - dual-mode hold selector drives slave only and is ignored when dual off
// - dual-mode fast-plus picks 1 MHz for the slave section
// - bit 0 of dual control enables dual mode, slave hold and fast-plus from it
// - run-while-halted 0 halts unit in debug break, 1 keeps it going
// - read irq request only while read-done flag and enable bit 7 set
// - write irq request only while write-done flag and enable bit 6 set
// - quick command sets read or write done flag on address ack
// - nonzero time-out field forces bus state idle after inactivity
// - time-out codes 0 off, 1 50 us, 2 100 us, 3 200 us
// - smart mode sends held ack choice when master data is read
// - bit 0 of master control first enables the master
module twcr_regs #(
    parameter int TMO_50  = twcr_pkg::TMO_50_CYC,
    parameter int TMO_100 = twcr_pkg::TMO_100_CYC,
    parameter int TMO_200 = twcr_pkg::TMO_200_CYC
) (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    // register port
    input  wire logic [4:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    // core events and status
    input  wire logic                 cpu_halted,
    input  wire logic                 addr_acked,
    input  wire logic                 addr_dir_read,
    input  wire logic                 byte_read_done,
    input  wire logic                 byte_write_done,
    input  wire logic                 bus_active,
    // configuration to the bus engines
    output twcr_pkg::twcr_cfg_s       master_cfg,
    output twcr_pkg::twcr_cfg_s       slave_cfg,
    output logic                      master_enable,
    output logic                      unit_run,
    output logic                      smart_ack_send,
    output logic                      ack_choice,
    output logic                      bus_idle_force,
    output logic      [2:0]           bus_state,
    // interrupts
    output logic                      master_irq,
    output logic                      event_irq
);
    import twcr_pkg::*;

    logic [7:0] common_r, common_nxt, dual_r, dual_nxt, dbg_r, dbg_nxt;
    logic [7:0] mctl1_r, mctl1_nxt, mctl2_r, mctl2_nxt;
    logic [7:0] store_r [OFS_MRATE:OFS_SMASK];
    logic [7:0] store_nxt [OFS_MRATE:OFS_SMASK];
    logic       rdf_r, rdf_nxt, wrf_r, wrf_nxt;
    logic [2:0] ev_r, ev_nxt, msk_r, msk_nxt;
    logic [7:0] rdata_nxt;
    logic [17:0] idle_cnt_r, idle_cnt_nxt;
    twcr_bus_e  bus_r, bus_nxt;
    twcr_cfg_s  mcfg_nxt, scfg_nxt, mcfg_r, scfg_r;
    logic       men_r, run_r, smart_r, ack_r, force_r, mirq_r, eirq_r;
    logic       smart_nxt, force_nxt;
    logic       run, hit_wr, tmo_hit;
    logic [17:0] tmo_lim;

    // decode a write hit on one register offset
    function automatic logic wr_hit(input logic [4:0] a, input logic [4:0] o,
                                    input logic w);
        return w && (a == o);
    endfunction

    function automatic logic [3:0] setup_of(input logic sel);
        return sel ? 4'(SETUP_LONG) : 4'(SETUP_SHORT);
    endfunction

    // halted in debug break unless run-while-halted is set
    assign run = !cpu_halted || dbg_r[RUN_BIT];
    assign hit_wr = reg_wr && (reg_addr[4] == 1'b0);

    // configuration registers: write masks keep reserved bits at zero
    always_comb
    begin
        common_nxt = common_r;
        dual_nxt   = dual_r;
        dbg_nxt    = dbg_r;
        mctl1_nxt  = mctl1_r;
        mctl2_nxt  = mctl2_r;
        msk_nxt    = msk_r;
        for (int i = OFS_MRATE; i <= OFS_SMASK; i++)
            store_nxt[i] = store_r[i];
        if (wr_hit(reg_addr, {1'b0, OFS_COMMON}, reg_wr))
            common_nxt = reg_wdata & WMASK_COMMON;
        if (wr_hit(reg_addr, {1'b0, OFS_DUAL}, reg_wr))
            dual_nxt = reg_wdata & WMASK_DUAL;
        if (wr_hit(reg_addr, {1'b0, OFS_DEBUG}, reg_wr))
            dbg_nxt = reg_wdata & WMASK_DEBUG;
        if (wr_hit(reg_addr, {1'b0, OFS_MCTL1}, reg_wr))
            mctl1_nxt = reg_wdata & WMASK_MCTL1;
        if (wr_hit(reg_addr, {1'b0, OFS_MCTL2}, reg_wr))
            mctl2_nxt = reg_wdata & WMASK_MCTL2;
        if (wr_hit(reg_addr, OFS_IRQ_MASK, reg_wr))
            msk_nxt = reg_wdata[2:0];
        // map entries from the master rate to the slave mask, except the slave state, are plain storage here
        for (int i = OFS_MRATE; i <= OFS_SMASK; i++)
            if (hit_wr && reg_addr[3:0] == 4'(i)
                && 4'(i) != OFS_MSTATE && 4'(i) != OFS_SSTATE)
                store_nxt[i] = reg_wdata;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            common_r <= RESET_VAL;
            dual_r   <= RESET_VAL;
            dbg_r    <= RESET_VAL;
            mctl1_r  <= RESET_VAL;
            mctl2_r  <= RESET_VAL;
            msk_r    <= 3'h0;
            for (int i = OFS_MRATE; i <= OFS_SMASK; i++)
                store_r[i] <= RESET_VAL;
        end
        else
        begin
            common_r <= common_nxt;
            dual_r   <= dual_nxt;
            dbg_r    <= dbg_nxt;
            mctl1_r  <= mctl1_nxt;
            mctl2_r  <= mctl2_nxt;
            msk_r    <= msk_nxt;
            for (int i = OFS_MRATE; i <= OFS_SMASK; i++)
                store_r[i] <= store_nxt[i];
        end
    end

    // effective configuration per section; dual fields ignored if off
    always_comb
    begin
        mcfg_nxt.hold      = common_r[HOLD_LSB +: 2];
        mcfg_nxt.fast_plus = common_r[FPLUS_BIT];
        mcfg_nxt.setup_cyc = setup_of(common_r[SETUP_BIT]);
        scfg_nxt           = mcfg_nxt;
        if (dual_r[DUAL_EN])
        begin
            scfg_nxt.hold      = dual_r[HOLD_LSB +: 2];
            scfg_nxt.fast_plus = dual_r[FPLUS_BIT];
        end
    end

    // master-done flags: a set in the same cycle as a clear wins
    always_comb
    begin
        logic clr_rd, clr_wr, qc;
        clr_rd = 1'b0;
        clr_wr = 1'b0;
        qc     = mctl1_r[QC_BIT] && addr_acked && run;
        if (wr_hit(reg_addr, {1'b0, OFS_MSTATE}, reg_wr))
        begin
            clr_rd = reg_wdata[RDF_BIT];
            clr_wr = reg_wdata[WRF_BIT];
        end
        // address, data access or command also clears both flags
        if (wr_hit(reg_addr, {1'b0, OFS_MADR}, reg_wr)
            || wr_hit(reg_addr, {1'b0, OFS_MCTL2}, reg_wr)
            || ((reg_wr || reg_rd) && reg_addr == {1'b0, OFS_MBYTE}))
        begin
            clr_rd = 1'b1;
            clr_wr = 1'b1;
        end
        rdf_nxt = (rdf_r && !clr_rd) || (run && byte_read_done)
                  || (qc && addr_dir_read);
        wrf_nxt = (wrf_r && !clr_wr) || (run && byte_write_done)
                  || (qc && !addr_dir_read);
        // smart mode acts on a master data read while enabled
        smart_nxt = reg_rd && reg_addr == {1'b0, OFS_MBYTE}
                    && mctl1_r[SMART_BIT] && mctl1_r[MEN_BIT]
                    && run;
        // sticky event bits, cleared by writing one
        ev_nxt = ev_r;
        if (wr_hit(reg_addr, {1'b0, OFS_IRQ_STAT}, reg_wr))
            ev_nxt = ev_r & ~reg_wdata[2:0];
        ev_nxt[EV_RD]  = ev_nxt[EV_RD] || (rdf_nxt && !rdf_r);
        ev_nxt[EV_WR]  = ev_nxt[EV_WR] || (wrf_nxt && !wrf_r);
        ev_nxt[EV_TMO] = ev_nxt[EV_TMO] || tmo_hit;
    end

    // time-out limit from field code
    always_comb
    begin
        case (mctl1_r[TMO_LSB +: 2])
            2'h1:    tmo_lim = 18'(TMO_50);
            2'h2:    tmo_lim = 18'(TMO_100);
            2'h3:    tmo_lim = 18'(TMO_200);
            default: tmo_lim = 18'h0;
        endcase
    end

    // a master already switched off in mctl1_r sees no time-out; one switched off this cycle still can
    assign tmo_hit = (tmo_lim != 18'h0) && run && bus_r == BS_BUSY
                     && mctl1_r[MEN_BIT] && !bus_active
                     && idle_cnt_r >= tmo_lim;

    // bus-state supervisor; unknown, idle and busy tracking, idle count and the idle forcing belong here
    always_comb
    begin
        idle_cnt_nxt = 18'h0;
        bus_nxt      = bus_r;
        force_nxt    = 1'b0;
        if (!mctl1_r[MEN_BIT])
            bus_nxt = BS_UNKNOWN;
        else if (!run)
        begin
            idle_cnt_nxt = idle_cnt_r; // frozen while halted
        end
        else
        begin
            case (bus_r)
                BS_UNKNOWN:
                    bus_nxt = bus_active ? BS_BUSY : BS_UNKNOWN;
                BS_IDLE:
                    bus_nxt = bus_active ? BS_BUSY : BS_IDLE;
                BS_BUSY:
                begin
                    if (bus_active)
                        idle_cnt_nxt = 18'h0;
                    else if (tmo_hit)
                    begin
                        bus_nxt   = BS_IDLE;
                        force_nxt = 1'b1;
                    end
                    else if (tmo_lim != 18'h0)
                        idle_cnt_nxt = idle_cnt_r + 18'h1;
                end
                default:
                    bus_nxt = BS_UNKNOWN;
            endcase
        end
    end

    // read mux, data stands in the cycle after the strobe
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                {1'b0, OFS_COMMON}:   rdata_nxt = common_r;
                {1'b0, OFS_DUAL}:     rdata_nxt = dual_r;
                {1'b0, OFS_DEBUG}:    rdata_nxt = dbg_r;
                {1'b0, OFS_MCTL1}:    rdata_nxt = mctl1_r;
                {1'b0, OFS_MCTL2}:    rdata_nxt = mctl2_r;
                {1'b0, OFS_MSTATE}:
                    rdata_nxt = {rdf_r, wrf_r, 6'h00};
                {1'b0, OFS_IRQ_STAT}: rdata_nxt = {5'h00, ev_r};
                OFS_IRQ_MASK:         rdata_nxt = {5'h00, msk_r};
                default:
                    if (!reg_addr[4] && reg_addr[3:0] >= OFS_MRATE
                        && reg_addr[3:0] != OFS_SSTATE)
                        rdata_nxt = store_r[reg_addr[3:0]];
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            rdf_r      <= 1'b0;
            wrf_r      <= 1'b0;
            ev_r       <= 3'h0;
            idle_cnt_r <= 18'h0;
            bus_r      <= BS_UNKNOWN;
            reg_rdata  <= 8'h00;
            mcfg_r     <= '0;
            scfg_r     <= '0;
            men_r      <= 1'b0;
            run_r      <= 1'b0;
            smart_r    <= 1'b0;
            ack_r      <= 1'b0;
            force_r    <= 1'b0;
            mirq_r     <= 1'b0;
            eirq_r     <= 1'b0;
        end
        else
        begin
            rdf_r      <= rdf_nxt;
            wrf_r      <= wrf_nxt;
            ev_r       <= ev_nxt;
            idle_cnt_r <= idle_cnt_nxt;
            bus_r      <= bus_nxt;
            reg_rdata  <= rdata_nxt;
            mcfg_r     <= mcfg_nxt;
            scfg_r     <= scfg_nxt;
            men_r      <= mctl1_nxt[MEN_BIT];
            run_r      <= run;
            smart_r    <= smart_nxt;
            ack_r      <= mctl2_r[ACK_BIT];
            force_r    <= force_nxt;
            mirq_r     <= (rdf_nxt && mctl1_nxt[READ_IRQ_ENABLE_BIT])
                          || (wrf_nxt && mctl1_nxt[WRITE_IRQ_ENABLE_BIT]);
            eirq_r     <= |(ev_nxt & msk_nxt);
        end
    end

    assign master_cfg     = mcfg_r;
    assign slave_cfg      = scfg_r;
    assign master_enable  = men_r;
    assign unit_run       = run_r;
    assign smart_ack_send = smart_r;
    assign ack_choice     = ack_r;
    assign bus_idle_force = force_r;
    assign bus_state      = bus_r;
    assign master_irq     = mirq_r;
    assign event_irq      = eirq_r;

    // checks
    // skip the first edge after reset, registered config is still zero
    property p_setup;
        @(posedge sys_clk) disable iff (!rst_b)
        $past(rst_b) |-> slave_cfg.setup_cyc
            == ($past(common_r[SETUP_BIT]) ? 4'(SETUP_LONG)
                                            : 4'(SETUP_SHORT));
    endproperty
    a_setup: assert property (p_setup)
        else $error("setup count not 4 or 8");
    property p_dual_ignored;
        @(posedge sys_clk) disable iff (!rst_b)
        !$past(dual_r[DUAL_EN]) |-> slave_cfg == master_cfg;
    endproperty
    a_dual_ignored: assert property (p_dual_ignored)
        else $error("slave cfg differs while dual off");
    property p_dual_fp;
        @(posedge sys_clk) disable iff (!rst_b)
        $past(dual_r[DUAL_EN]) |-> slave_cfg.fast_plus == $past(dual_r[1]);
    endproperty
    a_dual_fp: assert property (p_dual_fp)
        else $error("slave fast-plus not from dual reg");
    property p_rirq;
        @(posedge sys_clk) disable iff (!rst_b)
        (rdf_r && mctl1_r[READ_IRQ_ENABLE_BIT]) |-> master_irq;
    endproperty
    a_rirq: assert property (p_rirq)
        else $error("read irq missing");
    property p_wirq;
        @(posedge sys_clk) disable iff (!rst_b)
        master_irq |-> (rdf_r && mctl1_r[READ_IRQ_ENABLE_BIT])
                       || (wrf_r && mctl1_r[WRITE_IRQ_ENABLE_BIT]);
    endproperty
    a_wirq: assert property (p_wirq)
        else $error("master irq without cause");
    property p_qc;
        @(posedge sys_clk) disable iff (!rst_b)
        (mctl1_r[QC_BIT] && addr_acked && run && addr_dir_read) |=> rdf_r;
    endproperty
    a_qc: assert property (p_qc)
        else $error("quick read did not set flag");
    property p_tmo;
        @(posedge sys_clk) disable iff (!rst_b)
        tmo_hit |=> bus_state == BS_IDLE && bus_idle_force;
    endproperty
    a_tmo: assert property (p_tmo)
        else $error("time-out did not force idle");
    property p_halt;
        @(posedge sys_clk) disable iff (!rst_b)
        (cpu_halted && !dbg_r[RUN_BIT] && !rdf_r && !reg_wr
         && !mctl1_r[QC_BIT]) |=> !rdf_r;
    endproperty
    a_halt: assert property (p_halt)
        else $error("flag set while halted");
    property p_rd_lat;
        @(posedge sys_clk) disable iff (!rst_b)
        (reg_rd && reg_addr == {1'b0, OFS_MCTL1} && !$past(reg_wr))
        |=> reg_rdata == $past(mctl1_r);
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read data wrong");
    c_qc:    cover property (@(posedge sys_clk) rdf_r && mctl1_r[QC_BIT]);
    c_tmo:   cover property (@(posedge sys_clk) bus_idle_force);
    c_dual:  cover property (@(posedge sys_clk) dual_r[DUAL_EN]);
    c_irq:   cover property (@(posedge sys_clk) event_irq);
endmodule // twcr_regs

// File: test/twcr_far_side.sv
// far-side bus engine model: address acks, byte completions, activity
`timescale 1ns/100ps
module twcr_far_side (
    // clock
    input  wire logic sys_clk,
    // events toward the register block
    output logic      addr_acked,
    output logic      addr_dir_read,
    output logic      byte_read_done,
    output logic      byte_write_done,
    output logic      bus_active
);
    // quiet lines at time zero
    initial
    begin
        addr_acked      = 1'b0;
        addr_dir_read   = 1'b0;
        byte_read_done  = 1'b0;
        byte_write_done = 1'b0;
        bus_active      = 1'b0;
    end

    // slave acks the address; direction is only valid during the ack,
    // so it flips afterwards rather than lingering as a stale value
    task automatic ack(input logic rd);
        @(posedge sys_clk);
        addr_acked    <= 1'b1;
        addr_dir_read <= rd;
        @(posedge sys_clk);
        addr_acked    <= 1'b0;
        addr_dir_read <= ~rd;
    endtask

    // one byte completes in the chosen direction
    task automatic done(input logic rd);
        @(posedge sys_clk);
        byte_read_done  <= rd;
        byte_write_done <= ~rd;
        @(posedge sys_clk);
        byte_read_done  <= 1'b0;
        byte_write_done <= 1'b0;
    endtask

    // short burst of activity, then the bus falls silent
    task automatic burst();
        @(posedge sys_clk);
        bus_active <= 1'b1;
        repeat (3) @(posedge sys_clk);
        bus_active <= 1'b0;
    endtask
endmodule // twcr_far_side

// File: test/testbench.sv
// self-checking bench for the two-wire configuration registers
`timescale 1ns/100ps
module testbench;
    import twcr_pkg::*;
    // shortened time-out counts keep the run brief
    localparam int T50 = 5;
    localparam int T100 = 10;
    localparam int T200 = 20;
    logic       sys_clk, rst_b, reg_wr, reg_rd, cpu_halted;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    logic       addr_acked, addr_dir_read, byte_read_done;
    logic       byte_write_done, bus_active;
    twcr_cfg_s  master_cfg, slave_cfg;
    logic       master_enable, unit_run, smart_ack_send, ack_choice;
    logic       bus_idle_force, master_irq, event_irq;
    logic [2:0] bus_state;
    int         mismatches, total_checks, n_smart, n_force;

    twcr_regs #(.TMO_50(T50), .TMO_100(T100), .TMO_200(T200)) u_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cpu_halted(cpu_halted),
        .addr_acked(addr_acked), .addr_dir_read(addr_dir_read),
        .byte_read_done(byte_read_done),
        .byte_write_done(byte_write_done), .bus_active(bus_active),
        .master_cfg(master_cfg), .slave_cfg(slave_cfg),
        .master_enable(master_enable), .unit_run(unit_run),
        .smart_ack_send(smart_ack_send), .ack_choice(ack_choice),
        .bus_idle_force(bus_idle_force), .bus_state(bus_state),
        .master_irq(master_irq), .event_irq(event_irq));

    twcr_far_side u_far (
        .sys_clk(sys_clk), .addr_acked(addr_acked),
        .addr_dir_read(addr_dir_read), .byte_read_done(byte_read_done),
        .byte_write_done(byte_write_done), .bus_active(bus_active));

    // 100 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // pulse counters, so single-cycle outputs are never missed
    always @(posedge sys_clk)
    begin
        if (smart_ack_send === 1'b1) n_smart++;
        if (bus_idle_force === 1'b1) n_force++;
    end

    task automatic chk(input string nm, input logic [7:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [4:0] a);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 rv = reg_rdata;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic t_reset();
        chk("bus_state", {5'h0, BS_UNKNOWN}, {5'h0, bus_state});
        for (int a = 0; a < 17; a++)
        begin
            rd(a[4:0]);
            chk("reset value", RESET_VAL, rv);
        end
        rd(5'h1f);
        chk("unmapped", 8'h00, rv);
    endtask

    task automatic t_access();
        logic [4:0] ofs[6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h10};
        logic [7:0] msk[6] = '{WMASK_COMMON, WMASK_DUAL, WMASK_DEBUG,
                               WMASK_MCTL1, WMASK_MCTL2, WMASK_IRQ};
        for (int i = 0; i < 6; i++)
        begin
            wr(ofs[i], 8'hff);
            rd(ofs[i]);
            chk("written ones", msk[i], rv);
            wr(ofs[i], 8'h00);
            rd(ofs[i]);
            chk("written zeros", 8'h00, rv);
        end
    endtask

    task automatic t_config();
        logic [1:0] h;
        for (int i = 0; i < 4; i++)
        begin
            h = i[1:0];
            wr(5'h00, {3'h0, h[0], h, h[1], 1'b0});
            cyc(2);
            chk("master cfg", {1'b0, h, h[1], h[0] ? 4'h8 : 4'h4},
                {1'b0, master_cfg});
            chk("slave cfg", {1'b0, h, h[1], h[0] ? 4'h8 : 4'h4},
                {1'b0, slave_cfg});
        end
        wr(5'h01, 8'h0e);
        cyc(2);
        chk("dual off", 8'h78, {1'b0, slave_cfg});
        wr(5'h01, 8'h05);
        cyc(2);
        chk("dual slave", 8'h28, {1'b0, slave_cfg});
        chk("dual master", 8'h78, {1'b0, master_cfg});
        wr(5'h01, 8'h0b);
        cyc(2);
        chk("dual fplus", 8'h58, {1'b0, slave_cfg});
        wr(5'h01, 8'h00);
        wr(5'h00, 8'h00);
    endtask

    task automatic t_debug();
        @(posedge sys_clk);
        cpu_halted <= 1'b1;
        cyc(3);
        chk("halted", 8'h00, {7'h0, unit_run});
        wr(5'h02, 8'h01);
        cyc(2);
        chk("run halted", 8'h01, {7'h0, unit_run});
        @(posedge sys_clk);
        cpu_halted <= 1'b0;
        wr(5'h02, 8'h00);
        cyc(2);
        chk("running", 8'h01, {7'h0, unit_run});
    endtask

    task automatic t_irq();
        wr(5'h03, 8'hc1);
        u_far.done(1'b1);
        cyc(3);
        chk("read irq", 8'h01, {7'h0, master_irq});
        rd(5'h05);
        chk("read flag", 8'h80, rv & 8'hc0);
        rd(5'h0f);
        chk("event status", 8'h01, rv & 8'h07);
        wr(5'h10, 8'h01);
        cyc(2);
        chk("event irq", 8'h01, {7'h0, event_irq});
        wr(5'h10, 8'h00);
        cyc(2);
        chk("event masked", 8'h00, {7'h0, event_irq});
        wr(5'h0f, 8'h07);
        wr(5'h05, 8'h80);
        cyc(2);
        chk("read cleared", 8'h00, {7'h0, master_irq});
        wr(5'h03, 8'h81);
        u_far.done(1'b0);
        cyc(3);
        chk("write no enable", 8'h00, {7'h0, master_irq});
        wr(5'h03, 8'hc1);
        cyc(2);
        chk("write irq", 8'h01, {7'h0, master_irq});
        wr(5'h05, 8'h40);
        wr(5'h0f, 8'h07);
    endtask

    task automatic t_quick();
        for (int d = 1; d >= 0; d--)
        begin
            wr(5'h03, 8'h11);
            u_far.ack(d[0]);
            cyc(3);
            rd(5'h05);
            chk("quick flag", d ? 8'h80 : 8'h40, rv & 8'hc0);
            wr(5'h04, {6'h0, CMD_STOP});
            rd(5'h05);
            chk("after stop", 8'h00, rv & 8'hc0);
        end
    endtask

    task automatic t_smart();
        int n;
        wr(5'h04, 8'h04);
        wr(5'h03, 8'h03);
        cyc(2);
        chk("ack choice", 8'h01, {7'h0, ack_choice});
        chk("master on", 8'h01, {7'h0, master_enable});
        n = n_smart;
        rd(5'h08);
        cyc(3);
        chk("smart ack", 8'h01, 8'(n_smart - n));
        wr(5'h03, 8'h01);
        rd(5'h08);
        cyc(3);
        chk("no smart", 8'h01, 8'(n_smart - n));
        wr(5'h03, 8'h00);
        cyc(2);
        chk("master off", 8'h00, {7'h0, master_enable});
    endtask

    task automatic t_timeout();
        int tv[4] = '{0, T50, T100, T200};
        int n, k;
        for (int c = 0; c < 4; c++)
        begin
            wr(5'h03, {4'h0, c[1:0], 2'b01});
            n = n_force;
            u_far.burst();
            for (k = 0; k < 60 && bus_idle_force !== 1'b1; k++) cyc(1);
            if (c == 0)
                chk("no timeout", 8'h00, 8'(n_force - n));
            else
            begin
                chk("timeout span", 8'h01,
                    {7'h0, k >= tv[c] - 1 && k <= tv[c] + 4});
                cyc(1);
                chk("idle", {5'h0, BS_IDLE}, {5'h0, bus_state});
            end
        end
        wr(5'h03, 8'h00);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // cut a hang short
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        finish_test();
    end

    // main sequence
    initial
    begin
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
        cpu_halted = 1'b0;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        cyc(1);
        t_reset();
        t_access();
        t_config();
        t_debug();
        t_irq();
        t_quick();
        t_smart();
        t_timeout();
        finish_test();
    end
endmodule // testbench
